// File: fam_pkg.sv
// Constants for the flash array and security register address map
package fam_pkg;
    // Address layout
    localparam int ADDR_W        = 24;
    localparam int MAIN_AW       = 20;
    localparam int OFFSET_W      = 8;
    localparam int PAGE_LSB      = 8;
    localparam int PAGE_W        = 12;
    localparam int SECTOR_LSB    = 12;
    localparam int SECTOR_W      = 8;
    localparam int BLOCK_LSB     = 16;
    localparam int BLOCK_W       = 4;
    localparam int SR_SEL_LSB    = 12;
    localparam int SR_SEL_W      = 2;
    localparam int SR_COUNT      = 4;
    localparam int SR_BYTES      = 256;

    // Sizes in bytes
    localparam int SECTOR_BYTES  = 4096;
    localparam int BLOCK_BYTES   = 65536;
    localparam int ARRAY_BYTES   = 1048576;

    // Data values
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // Command codes
    localparam logic [7:0] CMD_READ        = 8'h03;
    localparam logic [7:0] CMD_PROGRAM     = 8'h02;
    localparam logic [7:0] CMD_SECTOR_ERS  = 8'h20;
    localparam logic [7:0] CMD_BLOCK_ERS   = 8'hD8;
    localparam logic [7:0] CMD_CHIP_ERS    = 8'hC7;
    localparam logic [7:0] CMD_PARAM_READ  = 8'h5A;
    localparam logic [7:0] CMD_SR_READ     = 8'h48;
    localparam logic [7:0] CMD_SR_PROGRAM  = 8'h42;
    localparam logic [7:0] CMD_SR_ERASE    = 8'h44;
    localparam logic [7:0] CMD_SR_LOCK     = 8'h4C;

    // Parameter space layout
    localparam logic [7:0] PT_PTR_OFF      = 8'h0C;
    localparam logic [7:0] PT_BASE         = 8'h10;

    // Sequencer states
    typedef enum logic [0:0] {
        FAM_IDLE  = 1'b0,
        FAM_ERASE = 1'b1
    } fam_state_e;
endpackage : fam_pkg

// File: fam_dec_if.sv
// Decoded address fields passed from decoder to sequencer
`timescale 1ns/100ps
interface fam_dec_if;
    import fam_pkg::*;
    logic [ADDR_W-1:0]   addr;
    logic [MAIN_AW-1:0]  main_addr;
    logic [MAIN_AW-1:0]  sector_base;
    logic [MAIN_AW-1:0]  block_base;
    logic [SECTOR_W-1:0] sector_idx;
    logic [BLOCK_W-1:0]  block_idx;
    logic [PAGE_W-1:0]   page_idx;
    logic                in_range;
    logic [SR_SEL_W-1:0] sr_sel;
    logic [OFFSET_W-1:0] sr_off;

    modport dec (input addr, output main_addr, sector_base, block_base,
                 sector_idx, block_idx, page_idx, in_range, sr_sel, sr_off);
    modport use_side (output addr, input main_addr, sector_base, block_base,
                      sector_idx, block_idx, page_idx, in_range, sr_sel,
                      sr_off);
endinterface : fam_dec_if

// File: fam_addr_decode.sv
// Address decoder: blocks, sectors, pages and security registers
`timescale 1ns/100ps
module fam_addr_decode
    import fam_pkg::*;
(
    fam_dec_if.dec d
);
    // Main array split by bit fields, every sector on the same pattern
    assign d.main_addr   = d.addr[MAIN_AW-1:0];
    assign d.in_range    = (d.addr[ADDR_W-1:MAIN_AW] == '0);
    assign d.sector_idx  = d.addr[SECTOR_LSB +: SECTOR_W];
    assign d.block_idx   = d.addr[BLOCK_LSB +: BLOCK_W];
    assign d.page_idx    = d.addr[PAGE_LSB +: PAGE_W];
    assign d.sector_base = {d.addr[MAIN_AW-1:SECTOR_LSB],
                            {SECTOR_LSB{1'b0}}};
    assign d.block_base  = {d.addr[MAIN_AW-1:BLOCK_LSB],
                            {BLOCK_LSB{1'b0}}};

    // Security register select and byte offset
    assign d.sr_sel = d.addr[SR_SEL_LSB +: SR_SEL_W];
    assign d.sr_off = d.addr[OFFSET_W-1:0];
endmodule : fam_addr_decode

// File: flash_array_address_map.sv
// Flash array and security register store with erase sequencer
`timescale 1ns/100ps
// Operation
// - Main array split into 256 sectors of 4 KB on aligned boundaries.
// - Sixteen 64 KB blocks, block k holds sectors 16k to 16k+15.
// - Each 256-byte page programs alone; programming only clears bits.
// - Erase by sector, block or chip only; no page erase exists.
// - Every sector decodes on the same low-twelve-bit pattern.
// - Four 256-byte security registers in their own address space.
// - A set lock bit write-protects its security register until srst clears it.
// - Register 0 holds parameter data, read with command 5A.
// - Registers 1 to 3 erase, program and lock independently.
// - Parameter space is read-only; program and erase are refused.
// - Parameter header at zero, basic table after it via pointer.
module flash_array_address_map
    import fam_pkg::*;
#(
    parameter int BLOCK_WALK = BLOCK_BYTES,
    parameter int CHIP_WALK  = ARRAY_BYTES
)
(
    input  wire logic              clock,
    input  wire logic              srst,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic [7:0]        req_cmd,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [7:0]        req_data,
    output logic                   rsp_valid,
    output logic                   rsp_refused,
    output logic [7:0]             rsp_data,
    output logic [SECTOR_W-1:0]    rsp_sector,
    output logic [BLOCK_W-1:0]     rsp_block,
    output logic [PAGE_W-1:0]      rsp_page,
    output logic [SR_COUNT-1:1]    sr_lock
);
    localparam logic [MAIN_AW-1:0] SECTOR_LAST =
        MAIN_AW'(SECTOR_BYTES - 1);
    localparam logic [MAIN_AW-1:0] BLOCK_LAST  = MAIN_AW'(BLOCK_WALK - 1);
    localparam logic [MAIN_AW-1:0] CHIP_LAST   = MAIN_AW'(CHIP_WALK - 1);
    localparam logic [MAIN_AW-1:0] SR_LAST     = MAIN_AW'(SR_BYTES - 1);

    // Read-only parameter space contents
    function automatic logic [7:0] param_byte(input logic [7:0] off);
        logic [7:0] b;
        b = ERASED_BYTE;
        case (off)
            8'h00:   b = 8'h53;
            8'h01:   b = 8'h46;
            8'h02:   b = 8'h44;
            8'h03:   b = 8'h50;
            8'h04:   b = 8'h06;
            8'h05:   b = 8'h01;
            8'h06:   b = 8'h00;
            8'h08:   b = 8'h00;
            8'h09:   b = 8'h06;
            8'h0A:   b = 8'h01;
            8'h0B:   b = 8'h01;
            PT_PTR_OFF: b = PT_BASE;
            8'h0D:   b = 8'h00;
            8'h0E:   b = 8'h00;
            default: b = ERASED_BYTE;
        endcase
        return b;
    endfunction : param_byte

    // Storage
    logic [7:0] main_mem [0:ARRAY_BYTES-1];
    logic [7:0] sr_mem   [1:SR_COUNT-1][0:SR_BYTES-1];

    // State
    fam_state_e          state_reg;
    fam_state_e          state_next;
    logic [MAIN_AW-1:0]  walk_ptr_reg;
    logic [MAIN_AW-1:0]  walk_ptr_next;
    logic [MAIN_AW-1:0]  walk_last_reg;
    logic [MAIN_AW-1:0]  walk_last_next;
    logic [MAIN_AW-1:0]  walk_base_reg;
    logic [MAIN_AW-1:0]  walk_base_next;
    logic                walk_sr_reg;
    logic                walk_sr_next;
    logic [SR_SEL_W-1:0] walk_sel_reg;
    logic [SR_SEL_W-1:0] walk_sel_next;
    logic [SR_COUNT-1:1] lock_reg;
    logic [SR_COUNT-1:1] lock_next;
    logic                rsp_valid_reg;
    logic                rsp_valid_next;
    logic                rsp_refused_reg;
    logic                rsp_refused_next;
    logic [7:0]          rsp_data_reg;
    logic [7:0]          rsp_data_next;
    logic [SECTOR_W-1:0] rsp_sector_reg;
    logic [BLOCK_W-1:0]  rsp_block_reg;
    logic [PAGE_W-1:0]   rsp_page_reg;

    // Address decode
    fam_dec_if dec_bus ();
    assign dec_bus.addr = req_addr;
    fam_addr_decode u_dec (
        .d (dec_bus.dec)
    );

    // Command decode
    wire is_read    = (req_cmd == CMD_READ);
    wire is_prog    = (req_cmd == CMD_PROGRAM);
    wire is_se      = (req_cmd == CMD_SECTOR_ERS);
    wire is_be      = (req_cmd == CMD_BLOCK_ERS);
    wire is_ce      = (req_cmd == CMD_CHIP_ERS);
    wire is_param   = (req_cmd == CMD_PARAM_READ);
    wire is_sr_rd   = (req_cmd == CMD_SR_READ);
    wire is_sr_prog = (req_cmd == CMD_SR_PROGRAM);
    wire is_sr_ers  = (req_cmd == CMD_SR_ERASE);
    wire is_sr_lock = (req_cmd == CMD_SR_LOCK);
    wire is_main    = is_read | is_prog | is_se | is_be;
    wire is_sr_wr   = is_sr_prog | is_sr_ers | is_sr_lock;
    // No page erase command: any other code is refused
    wire is_known   = is_main | is_ce | is_param | is_sr_rd
                    | is_sr_wr;

    // Security register protection
    wire [SR_SEL_W-1:0] sel      = dec_bus.sr_sel;
    wire                sel_usr  = (sel != '0);
    // Register 0 reads as locked, so no index falls outside the lock bits
    wire [SR_COUNT-1:0] lock_all = {lock_reg, 1'b1};
    wire                sel_lck  = lock_all[sel];
    // Writes to register 0 or to a locked register are refused
    wire                sr_deny  = is_sr_wr & sel_lck;

    // Request acceptance
    wire walking   = (state_reg == FAM_ERASE);
    wire take      = req_valid & req_ready;
    wire refuse    = ~is_known | (is_main & ~dec_bus.in_range) | sr_deny;
    wire ok        = take & ~refuse;
    wire start_ers = ok & (is_se | is_be | is_ce | is_sr_ers);
    wire walk_end  = walking & (walk_ptr_reg == walk_last_reg);
    assign req_ready = ~walking;

    // Main array write port
    // Read port shared by read and the read-modify of program
    wire [MAIN_AW-1:0] main_rd   = dec_bus.main_addr;
    wire [7:0]         main_old  = main_mem[main_rd];
    wire               main_we   = (ok & is_prog) | (walking & ~walk_sr_reg);
    wire [MAIN_AW-1:0] main_wa   = walking ? walk_base_reg + walk_ptr_reg
                                           : main_rd;
    wire [7:0]         main_wd   = walking ? ERASED_BYTE
                                           : main_old & req_data;

    // Security register write port
    wire [OFFSET_W-1:0] sr_off   = dec_bus.sr_off;
    wire [7:0]          sr_old   = sel_usr ? sr_mem[sel][sr_off]
                                           : param_byte(sr_off);
    wire                sr_we    = (ok & is_sr_prog) | (walking & walk_sr_reg);
    wire [SR_SEL_W-1:0] sr_ws    = walking ? walk_sel_reg : sel;
    wire [OFFSET_W-1:0] sr_wo    = walking ? walk_ptr_reg[OFFSET_W-1:0]
                                           : sr_off;
    wire [7:0]          sr_wd    = walking ? ERASED_BYTE
                                           : sr_old & req_data;

    // Main array storage
    always_ff @(posedge clock)
    begin
        if (main_we)
            main_mem[main_wa] <= main_wd;
    end

    // Security register storage, register 0 never written
    always_ff @(posedge clock)
    begin
        if (sr_we && sr_ws != '0)
            sr_mem[sr_ws][sr_wo] <= sr_wd;
    end

    // Erase walk setup and advance
    always_comb
    begin
        state_next     = state_reg;
        walk_ptr_next  = walk_ptr_reg;
        walk_last_next = walk_last_reg;
        walk_base_next = walk_base_reg;
        walk_sr_next   = walk_sr_reg;
        walk_sel_next  = walk_sel_reg;
        case (state_reg)
            FAM_IDLE:
            begin
                walk_ptr_next = '0;
                walk_sr_next  = is_sr_ers;
                walk_sel_next = sel;
                if (is_se)
                begin
                    walk_base_next = dec_bus.sector_base;
                    walk_last_next = SECTOR_LAST;
                end
                else if (is_be)
                begin
                    walk_base_next = dec_bus.block_base;
                    walk_last_next = BLOCK_LAST;
                end
                else if (is_ce)
                begin
                    walk_base_next = '0;
                    walk_last_next = CHIP_LAST;
                end
                else
                begin
                    walk_base_next = '0;
                    walk_last_next = SR_LAST;
                end
                if (start_ers)
                    state_next = FAM_ERASE;
            end
            FAM_ERASE:
            begin
                walk_ptr_next = walk_ptr_reg + MAIN_AW'(1);
                if (walk_end)
                    state_next = FAM_IDLE;
            end
            default:
                state_next = FAM_IDLE;
        endcase
    end

    // Lock bits are one-time: once set, only srst clears them
    for (genvar r = 1; r < SR_COUNT; r++)
    begin : g_lock
        wire hit = ok & is_sr_lock & (sel == SR_SEL_W'(r));
        assign lock_next[r] = lock_reg[r] | hit;
    end

    // Response data selection
    always_comb
    begin
        rsp_data_next = rsp_data_reg;
        if (ok & is_read)
            rsp_data_next = main_old;
        else if (ok & is_param)
            rsp_data_next = param_byte(sr_off);
        else if (ok & is_sr_rd)
            rsp_data_next = sr_old;
    end

    // One answer per take; an accepted erase answers when its walk ends
    assign rsp_valid_next   = (take & ~start_ers) | walk_end;
    assign rsp_refused_next = take & refuse;

    // Sequencer and response registers
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_reg       <= FAM_IDLE;
            walk_ptr_reg    <= '0;
            walk_last_reg   <= '0;
            walk_base_reg   <= '0;
            walk_sr_reg     <= 1'b0;
            walk_sel_reg    <= '0;
            lock_reg        <= '0;
            rsp_valid_reg   <= 1'b0;
            rsp_refused_reg <= 1'b0;
            rsp_data_reg    <= '0;
        end
        else
        begin
            state_reg       <= state_next;
            walk_ptr_reg    <= walk_ptr_next;
            walk_last_reg   <= walk_last_next;
            walk_base_reg   <= walk_base_next;
            walk_sr_reg     <= walk_sr_next;
            walk_sel_reg    <= walk_sel_next;
            lock_reg        <= lock_next;
            rsp_valid_reg   <= rsp_valid_next;
            rsp_refused_reg <= rsp_refused_next;
            rsp_data_reg    <= rsp_data_next;
        end
    end

    // Decoded location of the last request taken, refused or not
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            rsp_sector_reg <= '0;
            rsp_block_reg  <= '0;
            rsp_page_reg   <= '0;
        end
        else if (take)
        begin
            rsp_sector_reg <= dec_bus.sector_idx;
            rsp_block_reg  <= dec_bus.block_idx;
            rsp_page_reg   <= dec_bus.page_idx;
        end
    end

    // Outputs straight from registers
    assign rsp_valid   = rsp_valid_reg;
    assign rsp_refused = rsp_refused_reg;
    assign rsp_data    = rsp_data_reg;
    assign rsp_sector  = rsp_sector_reg;
    assign rsp_block   = rsp_block_reg;
    assign rsp_page    = rsp_page_reg;
    assign sr_lock     = lock_reg;
endmodule : flash_array_address_map

// File: fam_checker.sv
// Assertions on the ports of the flash address map block
`timescale 1ns/100ps
module fam_checker
    import fam_pkg::*;
#(
    parameter int BLOCK_WALK = BLOCK_BYTES,
    parameter int CHIP_WALK  = ARRAY_BYTES
)
(
    input wire logic                clock,
    input wire logic                srst,
    input wire logic                req_valid,
    input wire logic                req_ready,
    input wire logic [7:0]          req_cmd,
    input wire logic [ADDR_W-1:0]   req_addr,
    input wire logic [7:0]          req_data,
    input wire logic                rsp_valid,
    input wire logic                rsp_refused,
    input wire logic [7:0]          rsp_data,
    input wire logic [SECTOR_W-1:0] rsp_sector,
    input wire logic [BLOCK_W-1:0]  rsp_block,
    input wire logic [PAGE_W-1:0]   rsp_page,
    input wire logic [SR_COUNT-1:1] sr_lock
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // Request decode used by the properties
    wire        taken  = req_valid && req_ready;
    wire [23:0] dec_w  = {req_addr[19:16], req_addr[19:12], req_addr[19:8]};
    wire [3:0]  lk4    = {sr_lock, 1'b0};
    wire        sr_wr  = req_cmd inside {CMD_SR_PROGRAM, CMD_SR_ERASE,
                                         CMD_SR_LOCK};
    wire        main_c = req_cmd inside {CMD_READ, CMD_PROGRAM,
                                         CMD_SECTOR_ERS, CMD_BLOCK_ERS};
    wire        quick  = req_cmd inside {CMD_READ, CMD_PROGRAM,
                                         CMD_PARAM_READ, CMD_SR_READ};
    wire        known  = main_c || sr_wr || quick || req_cmd == CMD_CHIP_ERS;

    AST_ADDR_SPLIT:
    assert property (taken |=> {rsp_block, rsp_sector, rsp_page}
                               == $past(dec_w))
        else $error("address fields wrong");
    AST_QUICK_ANSWER:
    assert property (taken && quick |=> rsp_valid)
        else $error("no answer one cycle after request");
    AST_UNKNOWN_REFUSED:
    assert property (taken && !known |=> rsp_valid && rsp_refused)
        else $error("unknown code accepted");
    AST_RANGE_REFUSED:
    assert property (taken && main_c && req_addr[23:20] != 4'h0
                     |=> rsp_refused)
        else $error("out of range address accepted");
    AST_PARAM_READ_OK:
    assert property (taken && req_cmd == CMD_PARAM_READ
                     |=> rsp_valid && !rsp_refused)
        else $error("parameter read refused");
    AST_PARAM_RO:
    assert property (taken && sr_wr && req_addr[13:12] == 2'h0 |=> rsp_refused)
        else $error("parameter space write accepted");
    AST_LOCKED_REFUSED:
    assert property (taken && sr_wr && lk4[req_addr[13:12]] |=> rsp_refused)
        else $error("locked register write accepted");
    AST_LOCK_HOLDS:
    assert property (!$past(srst)
                     |-> (sr_lock & $past(sr_lock)) == $past(sr_lock))
        else $error("lock bit cleared");
    AST_ERASE_BUSY:
    assert property (taken && req_cmd == CMD_SECTOR_ERS
                     && req_addr[23:20] == 4'h0 |=> !req_ready [*8])
        else $error("sector erase not busy");
    AST_READY_WITH_RSP:
    assert property (!$past(srst) && $rose(req_ready) |-> rsp_valid)
        else $error("erase end without answer");

    // Main scenarios reached
    cover property (taken && req_cmd == CMD_SECTOR_ERS);
    cover property (taken && req_cmd == CMD_PARAM_READ);
    cover property ($rose(sr_lock[2]));
endmodule : fam_checker

bind flash_array_address_map fam_checker #(
    .BLOCK_WALK(BLOCK_WALK),
    .CHIP_WALK (CHIP_WALK)
) chk_u (.clock, .srst, .req_valid, .req_ready, .req_cmd, .req_addr,
         .req_data, .rsp_valid, .rsp_refused, .rsp_data, .rsp_sector,
         .rsp_block, .rsp_page, .sr_lock);

// File: fam_host.sv
// Host controller model issuing one request at a time
`timescale 1ns/100ps
module fam_host
    import fam_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         req_ready,
    output logic              req_valid,
    output logic [7:0]        req_cmd,
    output logic [ADDR_W-1:0] req_addr,
    output logic [7:0]        req_data
);
    // Quiet bus at time zero
    initial
    begin
        req_valid = 1'b0;
        req_cmd   = 8'h00;
        req_addr  = 24'h000000;
        req_data  = 8'h00;
    end

    // Hold a request until the edge where it is taken
    task automatic issue(input logic [7:0] c, input logic [23:0] a,
                         input logic [7:0] d);
        int n;
        @(negedge clock);
        req_valid = 1'b1;
        req_cmd   = c;
        req_addr  = a;
        req_data  = d;
        n = 0;
        @(posedge clock);
        while (req_ready !== 1'b1 && n < 6000)
        begin
            @(posedge clock);
            n++;
        end
    endtask : issue

    // Release; stale lines are inverted, not left showing old values
    task automatic idle();
        @(negedge clock);
        req_valid = 1'b0;
        req_cmd   = ~req_cmd;
        req_addr  = ~req_addr;
        req_data  = ~req_data;
    endtask : idle
endmodule : fam_host

// File: test_flash_array_address_map.sv
// Self-checking testbench for the flash address map block
`timescale 1ns/100ps
module test_flash_array_address_map;
    import fam_pkg::*;
    localparam logic [9:0] OK = 10'h000;
    localparam logic [9:0] NO = 10'h100;
    logic clock, srst, req_valid, req_ready, rsp_valid, rsp_refused;
    logic [7:0]  req_cmd, req_data, rsp_data;
    logic [23:0] req_addr;
    logic [7:0]  rsp_sector;
    logic [3:0]  rsp_block;
    logic [11:0] rsp_page;
    logic [3:1]  sr_lock;
    logic [9:0]  expq [$];
    logic [9:0]  exp_w;
    logic [15:0] sig [6] = '{16'h0053, 16'h0146, 16'h0244, 16'h0350,
                             16'h0406, 16'h0C10};
    logic [7:0]  known [10] = '{CMD_READ, CMD_PROGRAM, CMD_SECTOR_ERS,
        CMD_BLOCK_ERS, CMD_CHIP_ERS, CMD_PARAM_READ, CMD_SR_READ,
        CMD_SR_PROGRAM, CMD_SR_ERASE, CMD_SR_LOCK};
    int errors = 0, compares = 0, cycles = 0;

    flash_array_address_map #(.BLOCK_WALK(64), .CHIP_WALK(128)) dut_u (
        .clock, .srst, .req_valid, .req_ready, .req_cmd, .req_addr,
        .req_data, .rsp_valid, .rsp_refused, .rsp_data, .rsp_sector,
        .rsp_block, .rsp_page, .sr_lock);
    fam_host host_u (.clock, .req_ready, .req_valid, .req_cmd, .req_addr,
                     .req_data);

    always #4 clock = ~clock;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    // Note the expectation, then send the request
    task automatic req(input logic [7:0] c, input logic [23:0] a,
                       input logic [7:0] d, input logic [9:0] e);
        expq.push_back(e);
        host_u.issue(c, a, d);
    endtask : req

    task automatic fin(input string name);
        int n;
        host_u.idle();
        n = 0;
        while (expq.size() != 0 && n < 6000)
        begin
            @(posedge clock);
            n++;
        end
        @(negedge clock);
        $display("test %s done", name);
    endtask : fin

    // Match each answer against the oldest expectation
    always @(negedge clock)
    begin
        if (srst === 1'b0 && rsp_valid === 1'b1)
        begin
            exp_w = (expq.size() != 0) ? expq.pop_front() : 10'h3FF;
            check(rsp_refused, exp_w[8]);
            if (exp_w[9])
                check(rsp_data, exp_w[7:0]);
        end
    end

    // Hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            test_done();
        end
    end

    // Main sequence
    initial
    begin
        logic [23:0] a, b;
        logic [7:0]  c, d, d2;
        int i;
        clock = 1'b0;
        srst  = 1'b1;
        void'($urandom(32'hA560));
        repeat (6) @(negedge clock);
        srst = 1'b0;
        check({req_ready, rsp_valid, rsp_data, sr_lock}, 16'h1000);
        foreach (sig[i])
        begin
            a = {10'($urandom), 6'h00, sig[i][15:8]};
            req(CMD_PARAM_READ, {16'h0, sig[i][15:8]}, 8'h00,
                {2'b10, sig[i][7:0]});
            req(CMD_SR_READ, a, 8'h00, {2'b10, sig[i][7:0]});
        end
        foreach (known[i])
            if (known[i] inside {CMD_SR_PROGRAM, CMD_SR_ERASE, CMD_SR_LOCK})
                req(known[i], 24'h000000, 8'h00, NO);
        req(CMD_PARAM_READ, 24'h000000, 8'h00, 10'h253);
        // Follow the header pointer to the basic table
        req(CMD_PARAM_READ, {16'h0, sig[5][7:0]}, 8'h00, 10'h2FF);
        fin("param");
        a = {4'h0, 20'($urandom)};
        b = {a[23:12], 12'h000};
        d = 8'($urandom);
        d2 = 8'($urandom);
        req(CMD_SECTOR_ERS, a, 8'h00, OK);
        req(CMD_READ, b, 8'h00, 10'h2FF);
        req(CMD_READ, b + 24'hFFF, 8'h00, 10'h2FF);
        req(CMD_PROGRAM, a, d, OK);
        req(CMD_PROGRAM, a, d2, OK);
        req(CMD_READ, a, 8'h00, {2'b10, d & d2});
        fin("sector");
        check({rsp_block, rsp_page}, {a[19:16], a[19:8]});
        check(rsp_sector, a[19:12]);
        b = {4'h0, 4'($urandom), 16'h0000};
        req(CMD_SECTOR_ERS, b, 8'h00, OK);
        req(CMD_PROGRAM, b + 24'h5, 8'h00, OK);
        req(CMD_PROGRAM, b + 24'h40, 8'h00, OK);
        req(CMD_BLOCK_ERS, b + 24'(16'($urandom)), 8'h00, OK);
        req(CMD_READ, b + 24'h5, 8'h00, 10'h2FF);
        req(CMD_READ, b + 24'h40, 8'h00, 10'h200);
        req(CMD_SECTOR_ERS, 24'h000000, 8'h00, OK);
        req(CMD_PROGRAM, 24'h000007, 8'h00, OK);
        req(CMD_PROGRAM, 24'h000080, 8'h00, OK);
        req(CMD_CHIP_ERS, 24'h000000, 8'h00, OK);
        req(CMD_READ, 24'h000007, 8'h00, 10'h2FF);
        req(CMD_READ, 24'h000080, 8'h00, 10'h200);
        fin("erase");
        for (i = 0; i < 8; i++)
        begin
            c = (i == 0) ? 8'h81 : 8'($urandom);
            if (!(c inside {known}))
                req(c, 24'($urandom), 8'h00, NO);
        end
        req(CMD_READ, {4'h1 | 4'($urandom), 20'h0}, 8'h00, NO);
        fin("refuse");
        for (i = 1; i < 4; i++)
        begin
            a = {10'($urandom), 2'(i), 4'($urandom), 8'($urandom)};
            b = {10'($urandom), a[13:12], 4'($urandom), a[7:0]};
            d = 8'($urandom);
            req(CMD_SR_ERASE, a, 8'h00, OK);
            req(CMD_SR_READ, b, 8'h00, 10'h2FF);
            req(CMD_SR_PROGRAM, a, d, OK);
            req(CMD_SR_READ, b, 8'h00, {2'b10, d});
            if (i == 2)
                req(CMD_SR_LOCK, a, 8'h00, OK);
        end
        fin("secure");
        check(sr_lock, 16'h0002);
        req(CMD_SR_PROGRAM, 24'h002000, 8'h00, NO);
        req(CMD_SR_ERASE, 24'h002005, 8'h00, NO);
        req(CMD_SR_PROGRAM, 24'h003001, 8'h00, OK);
        fin("lock");
        test_done();
    end
endmodule : test_flash_array_address_map
